//--- rtl/pirqe_defs.vh
// constant definitions for the peripheral interrupt enable and priority block
// assumes it is included by bare name; definitions only
`ifndef PIRQE_DEFS_VH
`define PIRQE_DEFS_VH

// register offsets on the plain register port
`define PIRQE_OFS_EN4 4'h0
`define PIRQE_OFS_EN5 4'h1
`define PIRQE_OFS_EN6 4'h2
`define PIRQE_OFS_PRI1 4'h3
`define PIRQE_OFS_CTRL 4'h4
`define PIRQE_OFS_STAT 4'h5
`define PIRQE_OFS_CLR 4'h6
`define PIRQE_OFS_IEN 4'h7

// implemented-bit masks and reset values
`define PIRQE_MASK_EN4 8'hFF
`define PIRQE_MASK_EN5 8'h77
`define PIRQE_MASK_EN6 8'hF7
`define PIRQE_MASK_PRI1 8'hFF
`define PIRQE_RST_EN 8'h00
`define PIRQE_RST_PRI1 8'hFF

// control register fields
`define PIRQE_CTRL_PRIO_BIT 7
`define PIRQE_CTRL_GATE_BIT 6

// event status bits
`define PIRQE_EV_HIGH 0
`define PIRQE_EV_LOW 1
`define PIRQE_EV_GROUP 2

`endif

//--- rtl/pirqe_route.v
// one 8-bit request group: gates flags with enables and splits by priority
// assumes synchronous flag inputs in the clk_sys domain
`timescale 1ns/10ps

module pirqe_route
(
    input wire [7:0] flag,
    input wire [7:0] enable,
    input wire [7:0] priority_bits,
    input wire priority_levels_on,
    output wire [7:0] req_high,
    output wire [7:0] req_low
);

    wire [7:0] req;

    // a request needs both flag and enable; priority only counts when levels are on
    assign req = flag & enable;
    assign req_high = priority_levels_on ? (req & priority_bits) : req;
    assign req_low = priority_levels_on ? (req & ~priority_bits) : 8'h00;

endmodule // pirqe_route

//--- rtl/pirqe_top.v
// peripheral interrupt enable registers 4..6, priority register 1 and routing
// assumes synchronous inputs on clk_sys and a one-cycle strobe register port
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`include "pirqe_defs.vh"

module pirqe_top
(
    // clock and reset
    input wire clk_sys,
    input wire sys_rst,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_write,
    input wire reg_read,
    output reg [7:0] reg_rdata,
    // request flags and the enable register 1 held outside
    input wire [7:0] flags_4,
    input wire [7:0] flags_5,
    input wire [7:0] flags_6,
    input wire [7:0] flags_1,
    input wire [7:0] enable_1,
    // registered requests and the summary interrupt
    output reg irq_high,
    output reg irq_low,
    output reg irq_out
);

    // register map on the 4-bit port
    //   0 enable 4: capture/compare 10..4 and enhanced unit 3
    //   1 enable 5: clock tuning and timer enables, bits 7 and 3 read zero
    //   2 enable 6: serial ports four and three, comparators, bit 3 reads zero
    //   3 priority 1: one bit per group 1 source, one means high
    //   4 control: bit 7 levels on, bit 6 peripheral gate, bit 0 any request
    //   5 status, read only: bit 0 high rise, bit 1 low rise, bit 2 any rise
    //   6 status clear, write only: ones clear, a same-cycle event still sets
    //   7 interrupt enable for the three status bits
    // groups 4..6 have no priority register here and always route high

    // software-visible registers
    reg [7:0] periph_irq_enable_4;
    reg [7:0] periph_irq_enable_5;
    reg [7:0] periph_irq_enable_6;
    reg [7:0] periph_irq_priority_1;
    reg priority_levels_on;
    reg peripheral_irq_gate;
    reg [2:0] irq_status;
    reg [2:0] irq_enable;
    reg any_prev;
    // routed requests per group
    wire [7:0] high_4;
    wire [7:0] low_4;
    wire [7:0] high_5;
    wire [7:0] low_5;
    wire [7:0] high_6;
    wire [7:0] low_6;
    wire [7:0] high_1;
    wire [7:0] low_1;
    // combinational next values and status events
    reg next_high;
    reg next_low;
    reg [2:0] next_status;
    reg [7:0] next_rdata;
    wire next_any;
    wire [2:0] events;
    wire clr_write;

    // groups without priority registers here route high until their own bits exist
    pirqe_route u_route4
    (
        .flag(flags_4),
        .enable(periph_irq_enable_4),
        .priority_bits(`PIRQE_RST_PRI1),
        .priority_levels_on(priority_levels_on),
        .req_high(high_4),
        .req_low(low_4)
    );

    pirqe_route u_route5
    (
        .flag(flags_5),
        .enable(periph_irq_enable_5),
        .priority_bits(`PIRQE_RST_PRI1),
        .priority_levels_on(priority_levels_on),
        .req_high(high_5),
        .req_low(low_5)
    );

    pirqe_route u_route6
    (
        .flag(flags_6),
        .enable(periph_irq_enable_6),
        .priority_bits(`PIRQE_RST_PRI1),
        .priority_levels_on(priority_levels_on),
        .req_high(high_6),
        .req_low(low_6)
    );

    // group 1 uses the priority register held here
    pirqe_route u_route1
    (
        .flag(flags_1),
        .enable(enable_1),
        .priority_bits(periph_irq_priority_1),
        .priority_levels_on(priority_levels_on),
        .req_high(high_1),
        .req_low(low_1)
    );

    // combine groups; gate bit required when levels are off
    always @*
    begin
        next_high = |{high_4, high_5, high_6, high_1};
        next_low = |{low_4, low_5, low_6, low_1};
        if (!priority_levels_on)
        begin
            // levels off: one shared vector behind the peripheral gate
            next_high = next_high & peripheral_irq_gate;
            next_low = 1'b0;
        end
    end

    // rising edges of the request lines are the block's events
    assign next_any = next_high | next_low;
    assign events[`PIRQE_EV_HIGH] = next_high & ~irq_high;
    assign events[`PIRQE_EV_LOW] = next_low & ~irq_low;
    assign events[`PIRQE_EV_GROUP] = next_any & ~any_prev;
    assign clr_write = reg_write && (reg_addr == `PIRQE_OFS_CLR);

    // status next value: clear first, then set, so a same-cycle event wins
    always @*
    begin
        next_status = irq_status;
        if (clr_write)
        begin
            next_status = next_status & ~reg_wdata[2:0];
        end
        next_status = next_status | events;
    end

    // enable registers; unimplemented positions never take a one
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periph_irq_enable_4 <= `PIRQE_RST_EN;
            periph_irq_enable_5 <= `PIRQE_RST_EN;
            periph_irq_enable_6 <= `PIRQE_RST_EN;
        end
        else if (reg_write)
        begin
            if (reg_addr == `PIRQE_OFS_EN4)
            begin
                periph_irq_enable_4 <= reg_wdata & `PIRQE_MASK_EN4;
            end
            else if (reg_addr == `PIRQE_OFS_EN5)
            begin
                // bits 6,5 tuning; 4,2,0 timer match; 1 timer5 overflow
                periph_irq_enable_5 <= reg_wdata & `PIRQE_MASK_EN5;
            end
            else if (reg_addr == `PIRQE_OFS_EN6)
            begin
                periph_irq_enable_6 <= reg_wdata & `PIRQE_MASK_EN6;
            end
        end
    end

    // priority register 1 comes out of reset all high priority
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            periph_irq_priority_1 <= `PIRQE_RST_PRI1;
        end
        else if (reg_write && (reg_addr == `PIRQE_OFS_PRI1))
        begin
            periph_irq_priority_1 <= reg_wdata & `PIRQE_MASK_PRI1;
        end
    end

    // control register: priority levels switch and peripheral gate
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            priority_levels_on <= 1'b0;
            peripheral_irq_gate <= 1'b0;
        end
        else if (reg_write && (reg_addr == `PIRQE_OFS_CTRL))
        begin
            priority_levels_on <= reg_wdata[`PIRQE_CTRL_PRIO_BIT];
            peripheral_irq_gate <= reg_wdata[`PIRQE_CTRL_GATE_BIT];
        end
    end

    // interrupt enable for the three status bits
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_enable <= 3'h0;
        end
        else if (reg_write && (reg_addr == `PIRQE_OFS_IEN))
        begin
            irq_enable <= reg_wdata[2:0];
        end
    end

    // sticky status: set wins over a same-cycle clear
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_status <= 3'h0;
        end
        else
        begin
            irq_status <= next_status;
        end
    end

    // registered request outputs and the summary interrupt
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            irq_high <= 1'b0;
            irq_low <= 1'b0;
            irq_out <= 1'b0;
            any_prev <= 1'b0;
        end
        else
        begin
            irq_high <= next_high;
            irq_low <= next_low;
            irq_out <= |(irq_status & irq_enable);
            any_prev <= next_any;
        end
    end

    // read mux: unmapped, write-only and idle cycles give zero
    always @*
    begin
        next_rdata = 8'h00;
        if (reg_read)
        begin
            if (reg_addr == `PIRQE_OFS_EN4)
            begin
                next_rdata = periph_irq_enable_4;
            end
            else if (reg_addr == `PIRQE_OFS_EN5)
            begin
                next_rdata = periph_irq_enable_5 & `PIRQE_MASK_EN5;
            end
            else if (reg_addr == `PIRQE_OFS_EN6)
            begin
                next_rdata = periph_irq_enable_6 & `PIRQE_MASK_EN6;
            end
            else if (reg_addr == `PIRQE_OFS_PRI1)
            begin
                next_rdata = periph_irq_priority_1;
            end
            else if (reg_addr == `PIRQE_OFS_CTRL)
            begin
                next_rdata = {priority_levels_on, peripheral_irq_gate, 5'h00, any_prev};
            end
            else if (reg_addr == `PIRQE_OFS_STAT)
            begin
                next_rdata = {5'h00, irq_status};
            end
            else if (reg_addr == `PIRQE_OFS_IEN)
            begin
                next_rdata = {5'h00, irq_enable};
            end
        end
    end

    // read data stands only in the cycle after the strobe, zero otherwise
    always @(posedge clk_sys or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reg_rdata <= 8'h00;
        end
        else
        begin
            reg_rdata <= next_rdata;
        end
    end

endmodule // pirqe_top

//--- tb/pirqe_properties.sv
// concurrent checks on the ports of pirqe_top
// assumes one clock, clk_sys, with sys_rst as asynchronous reset
`timescale 1ns/10ps
module pirqe_properties
(
    input wire logic clk_sys, sys_rst, reg_write, reg_read, irq_high, irq_low, irq_out,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata, reg_rdata, flags_1, flags_4, flags_5, flags_6, enable_1
);
    // nothing pending anywhere, something pending in group one
    wire logic quiet = ((flags_1 & enable_1) | flags_4 | flags_5 | flags_6) == 8'h00;
    wire logic g1 = |(flags_1 & enable_1);
    logic w_d;
    logic [3:0] a_d;
    logic [7:0] v_d;
    // remembers the previous write so a following read can be judged
    always @(posedge clk_sys)
    begin
        w_d <= reg_write;
        a_d <= reg_addr;
        v_d <= reg_wdata;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    en4_readback_a: assert property (reg_read && w_d && a_d == 4'h0 && reg_addr == 4'h0
        |=> reg_rdata == $past(v_d)) else $error("enable 4 readback");
    en5_readback_a: assert property (reg_read && w_d && a_d == 4'h1 && reg_addr == 4'h1
        |=> reg_rdata == ($past(v_d) & 8'h77)) else $error("enable 5 readback");
    en6_readback_a: assert property (reg_read && w_d && a_d == 4'h2 && reg_addr == 4'h2
        |=> reg_rdata == ($past(v_d) & 8'hF7)) else $error("enable 6 readback");
    pri1_readback_a: assert property (reg_read && w_d && a_d == 4'h3 && reg_addr == 4'h3
        |=> reg_rdata == $past(v_d)) else $error("priority readback");
    unimpl_zero_a: assert property (reg_read && reg_addr == 4'h1 |=> !reg_rdata[7] && !reg_rdata[3])
        else $error("unimplemented bit set");
    read_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    quiet_request_a: assert property ($past(quiet) |-> !irq_high && !irq_low)
        else $error("request without flag");
    low_group_a: assert property (!$past(g1) |-> !irq_low)
        else $error("low request from high group");
endmodule // pirqe_properties
bind pirqe_top pirqe_properties pirqe_properties_i (.clk_sys, .sys_rst, .reg_write, .reg_read,
    .irq_high, .irq_low, .irq_out, .reg_addr, .reg_wdata, .reg_rdata, .flags_1, .flags_4,
    .flags_5, .flags_6, .enable_1);

//--- tb/pirqe_src_model.sv
// request source model: peripheral flags and the first enable register
// assumes the bench hands a packed value that is registered each edge
`timescale 1ns/10ps
module pirqe_src_model
(
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [39:0] src,
    output logic [7:0] enable_1, flags_1, flags_4, flags_5, flags_6
);
    // flags move only just after an edge, like registered peripheral logic
    always @(posedge clk_sys or posedge sys_rst)
        if (sys_rst)
            {enable_1, flags_1, flags_4, flags_5, flags_6} <= 40'h0;
        else
            {enable_1, flags_1, flags_4, flags_5, flags_6} <= src;
endmodule // pirqe_src_model

//--- tb/pirqe_top_test.sv
// self-checking bench for pirqe_top with the request source model
// assumes the rtl folder on the include path
`timescale 1ns/10ps
module pirqe_top_test;
    logic clk_sys = 0, sys_rst = 1, reg_write = 0, reg_read = 0, probe = 0, rd_d = 0, pr_d = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d, got;
    logic [39:0] src = 40'h0;
    logic [7:0] flags_1, flags_4, flags_5, flags_6, enable_1;
    logic irq_high, irq_low, irq_out;
    logic [8:0] q[$];
    logic [8:0] e;
    logic [7:0] msk[4] = '{8'hFF, 8'h77, 8'hF7, 8'hFF};
    int err_count = 0, tests_run = 0, cyc = 0, i;
    pirqe_top pirqe_top_i (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .flags_4, .flags_5, .flags_6, .flags_1, .enable_1, .irq_high, .irq_low, .irq_out);
    pirqe_src_model pirqe_src_model_i (.clk_sys, .sys_rst, .src, .enable_1, .flags_1, .flags_4,
        .flags_5, .flags_6);
    always #4 clk_sys = ~clk_sys;
    // hang guard
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            final_report();
        end
    end
    // compare each read or probe result with the oldest note
    always @(posedge clk_sys)
    begin
        rd_d <= reg_read;
        pr_d <= probe;
    end
    always @(negedge clk_sys)
        if (rd_d | pr_d)
        begin
            e = q.pop_front();
            tests_run++;
            got = e[8] ? {5'h00, irq_out, irq_low, irq_high} : reg_rdata;
            if (got !== e[7:0])
            begin
                err_count++;
                $display("unexpected at %0t: got %h want %h", $time, got, e[7:0]);
            end
        end
    // one bus cycle; a read or probe notes its expected value
    task op(input logic w, r, p, input logic [3:0] a, input logic [7:0] v);
        reg_write <= w;
        reg_read <= r;
        probe <= p;
        reg_addr <= a;
        reg_wdata <= v;
        if (r | p)
            q.push_back({p, v});
        @(posedge clk_sys);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] v); op(1'b1, 1'b0, 1'b0, a, v); endtask
    task rd(input logic [3:0] a, input logic [7:0] v); op(1'b0, 1'b1, 1'b0, a, v); endtask
    // sets the sources, lets them settle, then samples out, low, high
    task chk(input logic [39:0] s, input logic [7:0] v);
        src <= s;
        repeat (3) op(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
        op(1'b0, 1'b0, 1'b1, 4'h0, v);
    endtask
    task final_report;
        $display("tests %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        void'($urandom(32'h89A3613B));
        repeat (20) @(posedge clk_sys);
        sys_rst <= 1'b0;
        for (i = 0; i < 9; i++)
            rd(4'(i), i == 3 ? 8'hFF : 8'h00);
        $display("done reset values");
        for (i = 0; i < 4; i++)
        begin
            d = 8'($urandom);
            wr(4'(i), d);
            rd(4'(i), d & msk[i]);
            wr(4'(i), 8'hFF);
            rd(4'(i), msk[i]);
        end
        wr(4'h5, 8'hFF);
        rd(4'h5, 8'h00);
        wr(4'h9, 8'hFF);
        rd(4'h9, 8'h00);
        $display("done readback");
        wr(4'h4, 8'h40);
        for (i = 0; i < 24; i++)
        begin
            wr(4'(i / 8), 8'h01 << i % 8);
            chk(40'hFF << 8 * (2 - i / 8), {7'h00, msk[i / 8][i % 8]});
            wr(4'(i / 8), ~(8'h01 << i % 8));
            chk(40'h01 << (8 * (2 - i / 8) + i % 8), 8'h00);
        end
        $display("done per source gating");
        wr(4'h4, 8'h00);
        chk(40'h8080000000, 8'h00);
        wr(4'h4, 8'h80);
        chk(40'h8080000000, 8'h01);
        rd(4'h4, 8'h81);
        wr(4'h3, 8'h7F);
        chk(40'h8181000000, 8'h03);
        wr(4'h4, 8'h40);
        chk(40'h8080000000, 8'h01);
        chk(40'h0080000000, 8'h00);
        $display("done priority");
        wr(4'h6, 8'h07);
        wr(4'h7, 8'h03);
        rd(4'h5, 8'h00);
        wr(4'h4, 8'h80);
        chk(40'h8080000000, 8'h06);
        rd(4'h5, 8'h06);
        wr(4'h7, 8'h01);
        chk(40'h8080000000, 8'h02);
        wr(4'h7, 8'h02);
        wr(4'h6, 8'h02);
        chk(40'h8080000000, 8'h02);
        rd(4'h7, 8'h02);
        rd(4'h5, 8'h04);
        wr(4'h7, 8'h04);
        chk(40'h8080000000, 8'h06);
        wr(4'h6, 8'h04);
        chk(40'h8080000000, 8'h02);
        rd(4'h5, 8'h00);
        $display("done interrupt status");
        repeat (3) op(1'b0, 1'b0, 1'b0, 4'h0, 8'h00);
        final_report();
    end
endmodule // pirqe_top_test
